/* File: wdtc_defines.svh */
// Constants of the watchdog time-out control block
`ifndef WDTC_DEFINES_SVH
`define WDTC_DEFINES_SVH
// ==========================================================
// Register map
`define WDTC_ADDR_W 8
`define WDTC_CTRL_OFS 8'h21
`define WDTC_CTRL_RST 8'h00
// ==========================================================
// Control field positions
`define WDTC_UNLOCK_BIT 4
`define WDTC_ENABLE_BIT 3
`define WDTC_SEL_HI 2
`define WDTC_SEL_LO 0
// ==========================================================
// Timing
`define WDTC_UNLOCK_CYCLES 4
`define WDTC_SYS_HZ 25000000
`define WDTC_TICK_HZ 1000000
`define WDTC_TICK_DIV (`WDTC_SYS_HZ / `WDTC_TICK_HZ)
`define WDTC_BASE_TICKS 8192
`define WDTC_CNT_W 21
`endif

/* File: wdtc_pkg.sv */
// Types of the watchdog time-out control block
package wdtc_pkg;
   // ==========================================================
   // Time-out select codes
   typedef logic [2:0] wdtc_sel_type;
   // ==========================================================
   // Reset pulse state
   typedef enum logic [1:0] {
      WDTC_RUN = 2'b01,
      WDTC_FIRE = 2'b10
   } wdtc_state_type;
endpackage : wdtc_pkg

/* File: wdtc_watchdog.sv */
// Watchdog time-out control with control register and reset output
//
// Functional notes
// - Upper three control bits read zero; writes to them are dropped.
// - Unlock bit clears itself four clock cycles after being set.
// - Counting runs while enable is one, stops while zero.
// - Enable clears only while unlock is one; otherwise stays set.
// - Zero to enable within four cycles disables; later it is refused.
// - Select code n picks 8K times two to the n watchdog ticks.
// - Counter advances on a 1 MHz tick derived from system clock.
// - Restart instruction clears the count to zero.
// - Reaching the selected count without restart asserts system reset.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "wdtc_defines.svh"
module wdtc_watchdog
   import wdtc_pkg::*;
#(
   parameter int TICK_DIV = `WDTC_TICK_DIV,
   parameter int BASE_TICKS = `WDTC_BASE_TICKS
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [`WDTC_ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   input wire logic guardRestart,
   output logic sysReset
);
   localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
   localparam logic [2:0] UNLOCK_LAST = 3'(`WDTC_UNLOCK_CYCLES - 1);
   localparam logic [7:0] CTRL_RST = `WDTC_CTRL_RST;

   // ==========================================================
   // Decode
   function automatic logic hitCtrl(input logic [`WDTC_ADDR_W-1:0] a);
      return a == `WDTC_CTRL_OFS;
   endfunction : hitCtrl

   function automatic logic [`WDTC_CNT_W-1:0] limitOf(input wdtc_sel_type s);
      return `WDTC_CNT_W'(BASE_TICKS) << s;
   endfunction : limitOf

   // ==========================================================
   // Control register
   logic unlock_r, unlock_nxt;
   logic enable_r, enable_nxt;
   wdtc_sel_type sel_r, sel_nxt;
   logic [2:0] unlockCnt_r, unlockCnt_nxt;
   logic [7:0] regRdata_r, regRdata_nxt;
   logic wrCtrl;

   assign wrCtrl = regWrite && hitCtrl(regAddr);

   always_comb begin
      unlock_nxt = unlock_r;
      enable_nxt = enable_r;
      sel_nxt = sel_r;
      unlockCnt_nxt = unlockCnt_r;
      if (unlock_r) begin
         // Self clear after the fixed window
         if (unlockCnt_r == UNLOCK_LAST) begin
            unlock_nxt = 1'b0;
            unlockCnt_nxt = 3'h0;
         end else begin
            unlockCnt_nxt = unlockCnt_r + 3'h1;
         end
      end
      if (wrCtrl) begin
         sel_nxt = regWdata[`WDTC_SEL_HI:`WDTC_SEL_LO];
         if (regWdata[`WDTC_ENABLE_BIT]) begin
            enable_nxt = 1'b1;
         end else if (unlock_r) begin
            enable_nxt = 1'b0;
         end
         // Unlock only with enable written one in the same access
         if (regWdata[`WDTC_UNLOCK_BIT] && regWdata[`WDTC_ENABLE_BIT]) begin
            unlock_nxt = 1'b1;
            unlockCnt_nxt = 3'h0;
         end
      end
      regRdata_nxt = 8'h00;
      if (regRead && hitCtrl(regAddr)) begin
         regRdata_nxt = {3'h0, unlock_r, enable_r, sel_r};
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         unlock_r <= CTRL_RST[`WDTC_UNLOCK_BIT];
         enable_r <= CTRL_RST[`WDTC_ENABLE_BIT];
         sel_r <= CTRL_RST[`WDTC_SEL_HI:`WDTC_SEL_LO];
         unlockCnt_r <= 3'h0;
         regRdata_r <= 8'h00;
      end else begin
         unlock_r <= unlock_nxt;
         enable_r <= enable_nxt;
         sel_r <= sel_nxt;
         unlockCnt_r <= unlockCnt_nxt;
         regRdata_r <= regRdata_nxt;
      end
   end
   assign regRdata = regRdata_r;

   // ==========================================================
   // Tick divider and counter
   // Divider runs free so the tick phase never depends on restarts
   logic [DIV_W-1:0] div_r, div_nxt;
   logic tick;
   logic [`WDTC_CNT_W-1:0] cnt_r, cnt_nxt;
   wdtc_state_type state_r, state_nxt;
   logic sysReset_r, sysReset_nxt;

   assign tick = (div_r == DIV_LAST);

   always_comb begin
      div_nxt = tick ? '0 : div_r + DIV_W'(1);
      cnt_nxt = cnt_r;
      state_nxt = state_r;
      sysReset_nxt = 1'b0;
      case (state_r)
         WDTC_RUN: begin
            if (guardRestart) begin
               cnt_nxt = '0;
            end else if (enable_r && tick) begin
               if (cnt_r + `WDTC_CNT_W'(1) >= limitOf(sel_r)) begin
                  cnt_nxt = '0;
                  sysReset_nxt = 1'b1;
                  state_nxt = WDTC_FIRE;
               end else begin
                  cnt_nxt = cnt_r + `WDTC_CNT_W'(1);
               end
            end
         end
         WDTC_FIRE: begin
            // One-cycle reset pulse; system reset returns via nrst
            state_nxt = WDTC_RUN;
         end
         default: begin
            state_nxt = WDTC_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         div_r <= '0;
         cnt_r <= '0;
         state_r <= WDTC_RUN;
         sysReset_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         state_r <= state_nxt;
         sysReset_r <= sysReset_nxt;
      end
   end
   assign sysReset = sysReset_r;

   // ==========================================================
   // Checks
   sequence s_unlockWrite;
      wrCtrl && regWdata[`WDTC_UNLOCK_BIT] && regWdata[`WDTC_ENABLE_BIT];
   endsequence

   property p_unlockClear;
      @(posedge mclk) disable iff (!nrst)
      s_unlockWrite ##1 (!wrCtrl)[*4] |=> !unlock_r;
   endproperty
   a_unlockClear: assert property (p_unlockClear)
      else $error("unlock bit did not self clear");

   property p_unlockHold;
      @(posedge mclk) disable iff (!nrst)
      s_unlockWrite |=> unlock_r [*4];
   endproperty
   a_unlockHold: assert property (p_unlockHold)
      else $error("unlock bit dropped early");

   property p_readZero;
      @(posedge mclk) disable iff (!nrst)
      regRead |=> regRdata[7:5] == 3'h0;
   endproperty
   a_readZero: assert property (p_readZero)
      else $error("reserved bits read nonzero");

   property p_readCtrl;
      @(posedge mclk) disable iff (!nrst)
      regRead && hitCtrl(regAddr) |=>
         regRdata[4:0] == {$past(unlock_r), $past(enable_r), $past(sel_r)};
   endproperty
   a_readCtrl: assert property (p_readCtrl)
      else $error("control read mismatch");

   property p_refuseClear;
      @(posedge mclk) disable iff (!nrst)
      wrCtrl && !regWdata[`WDTC_ENABLE_BIT] && !unlock_r && enable_r
         |=> enable_r;
   endproperty
   a_refuseClear: assert property (p_refuseClear)
      else $error("enable cleared without unlock");

   property p_disable;
      @(posedge mclk) disable iff (!nrst)
      unlock_r && wrCtrl && !regWdata[`WDTC_ENABLE_BIT] |=> !enable_r;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disable sequence failed");

   property p_stopped;
      @(posedge mclk) disable iff (!nrst)
      !enable_r && !guardRestart |=> $stable(cnt_r) && !sysReset;
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("count moved while disabled");

   property p_restart;
      @(posedge mclk) disable iff (!nrst)
      guardRestart && state_r == WDTC_RUN |=> cnt_r == '0 && !sysReset;
   endproperty
   a_restart: assert property (p_restart)
      else $error("restart did not clear count");

   property p_expire;
      @(posedge mclk) disable iff (!nrst)
      state_r == WDTC_RUN && enable_r && tick && !guardRestart &&
         cnt_r == limitOf(sel_r) - `WDTC_CNT_W'(1) |=> sysReset;
   endproperty
   a_expire: assert property (p_expire)
      else $error("expiry did not reset");

   property p_noEarly;
      @(posedge mclk) disable iff (!nrst)
      sysReset |-> $past(cnt_r) + `WDTC_CNT_W'(1) >= limitOf($past(sel_r));
   endproperty
   a_noEarly: assert property (p_noEarly)
      else $error("reset before selected count");

   property p_tick;
      @(posedge mclk) disable iff (!nrst)
      tick |=> !tick;
   endproperty
   a_tick: assert property (p_tick)
      else $error("tick not divided");

   sequence s_windowIdle;
      (!wrCtrl) [*4];
   endsequence

   property p_lateRefuse;
      @(posedge mclk) disable iff (!nrst)
      s_unlockWrite ##1 s_windowIdle ##1
         (wrCtrl && !regWdata[`WDTC_ENABLE_BIT]) |=> enable_r;
   endproperty
   a_lateRefuse: assert property (p_lateRefuse)
      else $error("enable cleared after unlock window");

   property p_unlockPair;
      @(posedge mclk) disable iff (!nrst)
      wrCtrl && regWdata[`WDTC_UNLOCK_BIT] &&
         !regWdata[`WDTC_ENABLE_BIT] && !unlock_r |=> !unlock_r;
   endproperty
   a_unlockPair: assert property (p_unlockPair)
      else $error("unlock set without enable bit");

   property p_enableSet;
      @(posedge mclk) disable iff (!nrst)
      wrCtrl && regWdata[`WDTC_ENABLE_BIT] |=> enable_r;
   endproperty
   a_enableSet: assert property (p_enableSet)
      else $error("enable write not taken");

   property p_selWrite;
      @(posedge mclk) disable iff (!nrst)
      wrCtrl |=> sel_r == $past(regWdata[`WDTC_SEL_HI:`WDTC_SEL_LO]);
   endproperty
   a_selWrite: assert property (p_selWrite)
      else $error("select field not stored");

   property p_countStep;
      @(posedge mclk) disable iff (!nrst)
      state_r == WDTC_RUN && enable_r && tick && !guardRestart &&
         cnt_r + `WDTC_CNT_W'(1) < limitOf(sel_r)
         |=> cnt_r == $past(cnt_r) + `WDTC_CNT_W'(1);
   endproperty
   a_countStep: assert property (p_countStep)
      else $error("count did not advance on tick");

   // Release edge still applies reset, so gate on sampled nrst
   property p_divStep;
      @(posedge mclk) disable iff (!nrst)
      nrst && !tick |=> div_r == $past(div_r) + DIV_W'(1);
   endproperty
   a_divStep: assert property (p_divStep)
      else $error("divider skipped a step");

   property p_fireOnce;
      @(posedge mclk) disable iff (!nrst)
      sysReset |=> !sysReset;
   endproperty
   a_fireOnce: assert property (p_fireOnce)
      else $error("reset pulse longer than one cycle");

   property p_fireClear;
      @(posedge mclk) disable iff (!nrst)
      sysReset |-> cnt_r == '0;
   endproperty
   a_fireClear: assert property (p_fireClear)
      else $error("count not cleared on expiry");

   property p_idleRead;
      @(posedge mclk) disable iff (!nrst)
      !regRead |=> regRdata == 8'h00;
   endproperty
   a_idleRead: assert property (p_idleRead)
      else $error("read data outside read slot");
endmodule : wdtc_watchdog

/* File: wdtc_watchdog_test.sv */
// Self-checking testbench of the watchdog time-out control block
`timescale 1ns/1ps
`include "wdtc_defines.svh"
module wdtc_watchdog_test;
   import wdtc_pkg::*;
   // ==========================================================
   // Shortened counts keep the full select sweep brief
   localparam int DIV = 2;
   localparam int BASE = 4;
   localparam logic [7:0] CTRL = `WDTC_CTRL_OFS;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdata;
   logic guardRestart = 1'b0;
   logic sysReset;
   int nErrors = 0;
   int testsRun = 0;
   int cyc = 0;
   int fires = 0;
   int k;
   int f0;
   wdtc_watchdog #(.TICK_DIV(DIV), .BASE_TICKS(BASE)) dut (
      .mclk(mclk),
      .nrst(nrst),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regWrite(regWrite),
      .regRead(regRead),
      .regRdata(regRdata),
      .guardRestart(guardRestart),
      .sysReset(sysReset)
   );
   always #20 mclk = ~mclk;
   // ==========================================================
   // Pulse tally, so no one-cycle reset pulse is missed
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (sysReset === 1'b1) fires <= fires + 1;
      if (cyc == 20000) begin
         nErrors++;
         report_and_stop();
      end
   end
   // ==========================================================
   // Bus and compare helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 chk(regRdata, exp);
   endtask : rdchk
   task automatic kick();
      @(posedge mclk);
      guardRestart <= 1'b1;
      @(posedge mclk);
      guardRestart <= 1'b0;
   endtask : kick
   task automatic wait_fire(input int lim);
      k = 0;
      while (sysReset !== 1'b1 && k < lim) begin
         @(posedge mclk);
         #1 k++;
      end
   endtask : wait_fire
   task automatic turn_off(input logic [7:0] d);
      wr(CTRL, 8'h18);
      wr(CTRL, d);
   endtask : turn_off
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rdchk(CTRL, 8'h00);
      rdchk(8'h20, 8'h00);
      wr(8'h22, 8'h08);
      rdchk(CTRL, 8'h00);
      wr(CTRL, 8'hE5);
      rdchk(CTRL, 8'h05);
      wr(CTRL, 8'h08);
      wr(CTRL, 8'h00);
      rdchk(CTRL, 8'h08);
      wr(CTRL, 8'h18);
      rdchk(CTRL, 8'h18);
      repeat (4) @(posedge mclk);
      rdchk(CTRL, 8'h08);
      wr(CTRL, 8'h00);
      rdchk(CTRL, 8'h08);
      wr(CTRL, 8'h10);
      wr(CTRL, 8'h00);
      rdchk(CTRL, 8'h08);
      // Window edges: fifth cycle refused, fourth taken
      wr(CTRL, 8'h18);
      repeat (3) @(posedge mclk);
      wr(CTRL, 8'h00);
      rdchk(CTRL, 8'h08);
      wr(CTRL, 8'h18);
      repeat (2) @(posedge mclk);
      wr(CTRL, 8'h00);
      rdchk(CTRL, 8'h00);
      turn_off(8'h00);
      rdchk(CTRL, 8'h10);
      rdchk(CTRL, 8'h00);
   endtask : t_regs
   task automatic t_sweep();
      int n;
      for (int s = 0; s < 8; s++) begin
         n = DIV * (BASE << s);
         turn_off(s[7:0]);
         kick();
         wr(CTRL, 8'h08 | s[7:0]);
         wait_fire(n + 10);
         chk({7'h00, k >= n - 1 && k <= n}, 8'h01);
         @(posedge mclk);
         #1 chk({7'h00, sysReset}, 8'h00);
      end
   endtask : t_sweep
   task automatic t_restart();
      turn_off(8'h00);
      kick();
      wr(CTRL, 8'h08);
      f0 = fires;
      repeat (12) kick();
      #1 chk(fires[7:0] - f0[7:0], 8'h00);
      wait_fire(DIV * BASE + 10);
      chk({7'h00, sysReset}, 8'h01);
      turn_off(8'h00);
      f0 = fires;
      repeat (60) @(posedge mclk);
      #1 chk(fires[7:0] - f0[7:0], 8'h00);
   endtask : t_restart
   task automatic t_reselect();
      kick();
      wr(CTRL, 8'h0F);
      f0 = fires;
      repeat (30) @(posedge mclk);
      #1 chk(fires[7:0] - f0[7:0], 8'h00);
      // Count is already past the short limit, so expiry comes on the next tick
      wr(CTRL, 8'h08);
      wait_fire(DIV + 3);
      chk({7'h00, sysReset}, 8'h01);
   endtask : t_reselect
   task automatic t_reset();
      kick();
      wr(CTRL, 8'h1D);
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rdchk(CTRL, 8'h00);
      f0 = fires;
      repeat (40) @(posedge mclk);
      #1 chk(fires[7:0] - f0[7:0], 8'h00);
   endtask : t_reset
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      t_regs();
      t_sweep();
      t_restart();
      t_reselect();
      t_reset();
      report_and_stop();
   end
endmodule : wdtc_watchdog_test
